// ---- src/cssu_pkg.sv ----
// cssu_pkg: constants and carriers shared by the clamped subtract unit
package cssu_pkg;

   // instruction field positions (low halfword carries the opcode)
   localparam int OPC_LSB = 5;
   localparam int OPC_MSB = 10;
   localparam int DST_LSB = 11;
   localparam int DST_MSB = 15;
   localparam int SRC_LSB = 0;
   localparam int SRC_MSB = 4;
   localparam int IMM_LSB = 16;
   localparam int IMM_MSB = 31;

   // opcode field values, bits 10..5
   localparam logic [5:0] OP_SUB_REG = 6'h05;
   localparam logic [5:0] OP_ADD_REG = 6'h06;
   localparam logic [5:0] OP_SUB_IMM = 6'h33;

   // signed limits used when clamping
   localparam logic [31:0] CLAMP_POS = 32'h7fffffff;
   localparam logic [31:0] CLAMP_NEG = 32'h80000000;

   // register map, byte addresses on the 32-bit bus
   localparam int          ADDR_W     = 8;
   localparam logic [7:0]  OFF_STATUS = 8'h00;
   localparam logic [7:0]  OFF_CTRL   = 8'h04;
   localparam logic [7:0]  OFF_RESULT = 8'h08;
   localparam logic [7:0]  OFF_SATCNT = 8'h0c;

   // field positions and reset values
   localparam int          CTRL_EN_BIT  = 0;
   localparam int          CTRL_CLR_BIT = 1;
   localparam logic        CTRL_EN_RST  = 1'b1;
   localparam logic [4:0]  STATUS_RST   = 5'h00;
   localparam logic [31:0] RESULT_RST   = 32'h00000000;
   localparam logic [15:0] SATCNT_RST   = 16'h0000;

   // bus responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;

   // program status word flags, bit 4 down to bit 0
   typedef struct packed {
      logic clamp;
      logic borrow;
      logic ovf;
      logic s;
      logic z;
   } cssu_flags_t;

   // one instruction with its operands, from decoder and register file
   typedef struct packed {
      logic        valid;
      logic [31:0] instr;
      logic [31:0] srcVal;
      logic [31:0] dstVal;
   } cssu_issue_t;

   // write-back to the general register file
   typedef struct packed {
      logic        valid;
      logic [4:0]  index;
      logic [31:0] data;
   } cssu_wb_t;

endpackage : cssu_pkg

// ---- src/cssu_arith.sv ----
// cssu_arith: 32-bit add or subtract with clamping to the signed limits
`timescale 1ns/1ns
`default_nettype none
module cssu_arith (
   input  wire logic [31:0] opA,
   input  wire logic [31:0] opB,
   input  wire logic        isAdd,
   output logic      [31:0] result,
   output logic             carry,
   output logic             ovf
);
   import cssu_pkg::*;

   logic [32:0] wide;

   // one 33-bit adder; bit 32 is carry out on add and borrow on subtract
   always_comb begin
      if (isAdd) begin
         wide = {1'b0, opA} + {1'b0, opB};
         ovf  = (opA[31] == opB[31]) && (wide[31] != opA[31]);
      end else begin
         wide = {1'b0, opA} - {1'b0, opB};
         ovf  = (opA[31] != opB[31]) && (wide[31] != opA[31]);
      end
      carry = wide[32];
      // overflow direction always follows the sign of the first operand
      if (ovf) begin
         result = opA[31] ? CLAMP_NEG : CLAMP_POS;
      end else begin
         result = wide[31:0];
      end
   end

endmodule : cssu_arith
`default_nettype wire

// ---- src/cssu_top.sv ----
// cssu_top: clamped subtract/add execution unit with its status word
//
// Summary of operation
// - register form: destination minus source, to destination
// - immediate form: source minus sign-extended immediate
// - immediate opcode in low halfword, immediate high
// - overflow clamps to signed maximum or minimum
// - carry flag shows borrow out of the top, carry out on add
// - overflow flag shows signed overflow
// - sign flag follows the written result
// - zero flag set when written result is zero
// - sticky clamp flag set on overflow
// - clamp flag never cleared by arithmetic
// - existing clamp flag changes nothing else
// - register add uses the same clamping
`timescale 1ns/1ns
`default_nettype none
module cssu_top (
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   input  wire cssu_pkg::cssu_issue_t       issue,
   output var   cssu_pkg::cssu_wb_t         wb,
   output var   cssu_pkg::cssu_flags_t      status,
   input  wire logic [cssu_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [cssu_pkg::ADDR_W-1:0] araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [31:0]                      rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready
);
   import cssu_pkg::*;

   typedef enum logic [1:0] {
      WS_IDLE = 2'h1,
      WS_RESP = 2'h2
   } cssu_wstate_t;

   typedef enum logic [1:0] {
      RS_IDLE = 2'h1,
      RS_DATA = 2'h2
   } cssu_rstate_t;

   // true when the byte offset names a register of this block
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == OFF_STATUS) || (a == OFF_CTRL) || (a == OFF_RESULT)
               || (a == OFF_SATCNT);
   endfunction : mapped

   // state registers
   cssu_wstate_t        wsReg, wsNext;
   cssu_rstate_t        rsReg, rsNext;
   logic                awGotReg, awGotNext;
   logic                wGotReg, wGotNext;
   logic [ADDR_W-1:0]   awAddrReg, awAddrNext;
   logic [31:0]         wDataReg, wDataNext;
   logic                wStrbReg, wStrbNext;
   logic                awreadyReg, awreadyNext;
   logic                wreadyReg, wreadyNext;
   logic                bvalidReg, bvalidNext;
   logic [1:0]          brespReg, brespNext;
   logic                arreadyReg, arreadyNext;
   logic                rvalidReg, rvalidNext;
   logic [31:0]         rdataReg, rdataNext;
   logic [1:0]          rrespReg, rrespNext;
   cssu_flags_t         statusReg, statusNext;
   logic                ctrlEnReg, ctrlEnNext;
   logic [31:0]         resultReg, resultNext;
   logic [15:0]         clampCntReg, clampCntNext;
   cssu_wb_t            wbReg, wbNext;

   // decode and datapath wires
   logic [5:0]          opcode;
   logic                isSubR, isAddR, isSubI, accept;
   logic [31:0]         opA, opB, immExt;
   logic [31:0]         aluRes;
   logic                aluCarry, aluOvf;
   logic                awFire, wFire, doWrite;
   logic [ADDR_W-1:0]   wAddr;
   logic [31:0]         wVal;
   logic                wLane0;
   logic                statusWrite, ctrlWrite;

   // opcode lives in the low halfword, immediate in the high one
   always_comb begin
      opcode = issue.instr[OPC_MSB:OPC_LSB];
      isSubR = (opcode == OP_SUB_REG);
      isAddR = (opcode == OP_ADD_REG);
      isSubI = (opcode == OP_SUB_IMM);
      immExt = {{16{issue.instr[IMM_MSB]}}, issue.instr[IMM_MSB:IMM_LSB]};
      // unknown opcodes and a disabled unit write nothing back
      accept = issue.valid && ctrlEnReg && (isSubR || isAddR || isSubI);
      // immediate form reads only the source operand
      opA = isSubI ? issue.srcVal : issue.dstVal;
      opB = isSubI ? immExt : issue.srcVal;
   end

   // clamped arithmetic; the sticky flag is deliberately not an input
   cssu_arith u_arith (
      .opA    (opA),
      .opB    (opB),
      .isAdd  (isAddR),
      .result (aluRes),
      .carry  (aluCarry),
      .ovf    (aluOvf)
   );

   // bus write channel handshakes, address and data in either order
   always_comb begin
      awFire  = awvalid && awreadyReg;
      wFire   = wvalid && wreadyReg;
      wAddr   = awFire ? awaddr : awAddrReg;
      wVal    = wFire ? wdata : wDataReg;
      wLane0  = wFire ? wstrb[0] : wStrbReg;
      doWrite = (wsReg == WS_IDLE) && (awGotReg || awFire) && (wGotReg || wFire);
      statusWrite = doWrite && wLane0 && (wAddr == OFF_STATUS);
      ctrlWrite = doWrite && wLane0 && (wAddr == OFF_CTRL);
   end

   // write state machine next values
   always_comb begin
      wsNext      = wsReg;
      awGotNext   = awGotReg;
      wGotNext    = wGotReg;
      awAddrNext  = awAddrReg;
      wDataNext   = wDataReg;
      wStrbNext   = wStrbReg;
      bvalidNext  = bvalidReg;
      brespNext   = brespReg;
      unique case (wsReg)
         WS_IDLE: begin
            if (awFire) begin
               awGotNext  = 1'b1;
               awAddrNext = awaddr;
            end
            if (wFire) begin
               wGotNext  = 1'b1;
               wDataNext = wdata;
               wStrbNext = wstrb[0];
            end
            if (doWrite) begin
               wsNext     = WS_RESP;
               bvalidNext = 1'b1;
               brespNext  = mapped(wAddr) ? RESP_OKAY : RESP_DECERR;
            end
         end
         WS_RESP: begin
            // response stands until the master takes it
            if (bready) begin
               wsNext     = WS_IDLE;
               bvalidNext = 1'b0;
               awGotNext  = 1'b0;
               wGotNext   = 1'b0;
            end
         end
      endcase
      // one write at a time: channels reopen only after the response
      awreadyNext = (wsNext == WS_IDLE) && !awGotNext;
      wreadyNext  = (wsNext == WS_IDLE) && !wGotNext;
   end

   // read state machine next values
   always_comb begin
      rsNext      = rsReg;
      arreadyNext = arreadyReg;
      rvalidNext  = rvalidReg;
      rdataNext   = rdataReg;
      rrespNext   = rrespReg;
      unique case (rsReg)
         RS_IDLE: begin
            if (arvalid && arreadyReg) begin
               rsNext      = RS_DATA;
               arreadyNext = 1'b0;
               rvalidNext  = 1'b1;
               rrespNext   = mapped(araddr) ? RESP_OKAY : RESP_DECERR;
               // unused bits and unmapped offsets read as zero
               unique case (araddr)
                  OFF_STATUS: rdataNext = {27'h0, statusReg};
                  OFF_CTRL:   rdataNext = {31'h0, ctrlEnReg};
                  OFF_RESULT: rdataNext = resultReg;
                  OFF_SATCNT: rdataNext = {16'h0000, clampCntReg};
                  default:    rdataNext = 32'h00000000;
               endcase
            end
         end
         RS_DATA: begin
            if (rready) begin
               rsNext      = RS_IDLE;
               arreadyNext = 1'b1;
               rvalidNext  = 1'b0;
            end
         end
      endcase
   end

   // execution: status word, result capture and write-back
   always_comb begin
      statusNext   = statusReg;
      ctrlEnNext   = ctrlEnReg;
      resultNext   = resultReg;
      clampCntNext = clampCntReg;
      wbNext       = '0;
      // status load from software; the only way the sticky flag falls
      if (statusWrite) begin
         statusNext = cssu_flags_t'(wVal[4:0]);
      end
      if (ctrlWrite) begin
         ctrlEnNext = wVal[CTRL_EN_BIT];
         if (wVal[CTRL_CLR_BIT]) begin
            clampCntNext = SATCNT_RST;
         end
      end
      if (accept) begin
         // an instruction overrides the borrow, ovf, s and z bits of a status load in the same cycle
         statusNext.borrow = aluCarry;
         statusNext.ovf    = aluOvf;
         statusNext.s      = aluRes[31];
         statusNext.z      = (aluRes == 32'h00000000);
         // set wins over a simultaneous clear by software
         statusNext.clamp = statusNext.clamp | aluOvf;
         resultNext  = aluRes;
         if (aluOvf) begin
            clampCntNext = clampCntNext + 16'h0001;
         end
         wbNext.valid = 1'b1;
         wbNext.index = issue.instr[DST_MSB:DST_LSB];
         wbNext.data  = aluRes;
      end
   end

   // all state registered here only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wsReg      <= WS_IDLE;
         rsReg      <= RS_IDLE;
         awGotReg   <= 1'b0;
         wGotReg    <= 1'b0;
         awAddrReg  <= '0;
         wDataReg   <= 32'h00000000;
         wStrbReg   <= 1'b0;
         awreadyReg <= 1'b1;
         wreadyReg  <= 1'b1;
         bvalidReg  <= 1'b0;
         brespReg   <= RESP_OKAY;
         arreadyReg <= 1'b1;
         rvalidReg  <= 1'b0;
         rdataReg   <= 32'h00000000;
         rrespReg   <= RESP_OKAY;
         statusReg  <= cssu_flags_t'(STATUS_RST);
         ctrlEnReg  <= CTRL_EN_RST;
         resultReg  <= RESULT_RST;
         clampCntReg <= SATCNT_RST;
         wbReg      <= '0;
      end else begin
         wsReg      <= wsNext;
         rsReg      <= rsNext;
         awGotReg   <= awGotNext;
         wGotReg    <= wGotNext;
         awAddrReg  <= awAddrNext;
         wDataReg   <= wDataNext;
         wStrbReg   <= wStrbNext;
         awreadyReg <= awreadyNext;
         wreadyReg  <= wreadyNext;
         bvalidReg  <= bvalidNext;
         brespReg   <= brespNext;
         arreadyReg <= arreadyNext;
         rvalidReg  <= rvalidNext;
         rdataReg   <= rdataNext;
         rrespReg   <= rrespNext;
         statusReg  <= statusNext;
         ctrlEnReg  <= ctrlEnNext;
         resultReg  <= resultNext;
         clampCntReg <= clampCntNext;
         wbReg      <= wbNext;
      end
   end

   // outputs straight from flops
   assign wb      = wbReg;
   assign status  = statusReg;
   assign awready = awreadyReg;
   assign wready  = wreadyReg;
   assign bvalid  = bvalidReg;
   assign bresp   = brespReg;
   assign arready = arreadyReg;
   assign rvalid  = rvalidReg;
   assign rdata   = rdataReg;
   assign rresp   = rrespReg;

   // exact 33-bit difference, computed apart from the datapath for checking
   logic [32:0] exact;
   logic        exactOvf;
   always_comb begin
      exact    = {opA[31], opA} - {opB[31], opB};
      exactOvf = (exact[32] != exact[31]);
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_wb_dest_index: assert property (accept |=> wb.valid
      && wb.index == $past(issue.instr[15:11]))
      else $error("write-back index not taken from bits 15..11");
   a_reg_sub_zero: assert property (accept && isSubR && issue.srcVal == 0
      |=> wb.data == $past(issue.dstVal))
      else $error("register subtract of zero altered destination");
   a_imm_sub_value: assert property (accept && isSubI && !exactOvf
      |=> wb.data == $past(exact[31:0]))
      else $error("immediate subtract gave wrong difference");
   a_clamp_pos_max: assert property (accept && !isAddR && exactOvf && !exact[32]
      |=> wb.data == CLAMP_POS)
      else $error("positive overflow not clamped to maximum");
   a_clamp_neg_min: assert property (accept && !isAddR && exactOvf && exact[32]
      |=> wb.data == CLAMP_NEG)
      else $error("negative overflow not clamped to minimum");
   a_borrow_flag: assert property (accept && !isAddR
      |=> status.borrow == ($past(opA) < $past(opB)))
      else $error("borrow flag does not match unsigned compare");
   a_ovf_flag_sub: assert property (accept && !isAddR
      |=> status.ovf == $past(exactOvf))
      else $error("overflow flag wrong for subtract");
   a_sign_flag: assert property (accept |=> status.s == wb.data[31])
      else $error("sign flag does not follow written result");
   a_zero_flag: assert property (accept |=> status.z == (wb.data == 0))
      else $error("zero flag does not follow written result");
   a_clamp_on_ovf: assert property (accept && aluOvf |=> status.clamp && status.ovf)
      else $error("sticky clamp flag not set on overflow");
   a_clamp_sticky: assert property (status.clamp && !statusWrite |=> status.clamp)
      else $error("sticky clamp flag fell without a status load");
   a_add_zero_src: assert property (accept && isAddR && issue.srcVal == 0
      |=> wb.data == $past(issue.dstVal) && !status.borrow)
      else $error("register add of zero altered destination");
   a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");

   c_reg_sub: cover property (accept && isSubR ##1 wb.valid);
   c_imm_clamp: cover property (accept && isSubI && aluOvf);
   c_add_clamp: cover property (accept && isAddR && aluOvf);
   c_clamp_cleared: cover property (status.clamp ##1 statusWrite ##1 !status.clamp);

endmodule : cssu_top
`default_nettype wire

// ---- test/cssu_regfile_model.sv ----
// cssu_regfile_model: register file and issue stage feeding the clamped subtract unit
`timescale 1ns/1ns
`default_nettype none
module cssu_regfile_model (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic                 reqValid,
   input  wire logic [31:0]          reqInstr,
   input  wire logic                 ldEn,
   input  wire logic [4:0]           ldIdx,
   input  wire logic [31:0]          ldData,
   input  wire cssu_pkg::cssu_wb_t   wb,
   output var  cssu_pkg::cssu_issue_t issue
);
   import cssu_pkg::*;
   logic [31:0] regFile_reg [32];
   cssu_issue_t issue_reg;
   cssu_issue_t issue_next;

   // idle slots show inverted payload so a stale operand never looks valid
   always_comb begin
      issue_next = {1'b0, ~issue_reg.instr, ~issue_reg.srcVal, ~issue_reg.dstVal};
      if (reqValid) begin
         issue_next.valid  = 1'b1;
         issue_next.instr  = reqInstr;
         issue_next.srcVal = regFile_reg[reqInstr[4:0]];
         issue_next.dstVal = regFile_reg[reqInstr[15:11]];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         issue_reg <= '0;
      else
         issue_reg <= issue_next;
   end

   // only the written-back and loaded indices change; no hazard bypass, so dependent ops need a gap
   always_ff @(posedge mclk) begin
      if (wb.valid)
         regFile_reg[wb.index] <= wb.data;
      if (ldEn)
         regFile_reg[ldIdx] <= ldData;
   end

   assign issue = issue_reg;
endmodule : cssu_regfile_model
`default_nettype wire

// ---- test/tb_top.sv ----
// tb_top: self-checking bench for the clamped subtract unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import cssu_pkg::*;
   logic        mclk, rst_n, reqValid, ldEn, clampExp;
   logic [31:0] reqInstr, ldData, wdata, rdata;
   logic [4:0]  ldIdx;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [4:0]  statusExp;
   cssu_wb_t    wb;
   cssu_flags_t status;
   cssu_issue_t issue;
   int          errCount, checkCount, ovfCount;
   logic [31:0] va [7] = '{32'd10, 32'd3, 32'd5, 32'h7fffffff, 32'h80000000, 32'd9, 32'hfffffff0};
   logic [31:0] vb [7] = '{32'd3, 32'd10, 32'd5, 32'hffffffff, 32'd1, 32'd2, 32'hfffffff0};
   logic [31:0] is [4] = '{32'd5, 32'h7fffffff, 32'h80000000, 32'd0};
   logic [15:0] im [4] = '{16'h0001, 16'hffff, 16'h0001, 16'h8000};

   cssu_top uut (.mclk(mclk), .rst_n(rst_n), .issue(issue), .wb(wb), .status(status),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   cssu_regfile_model model (.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid),
      .reqInstr(reqInstr), .ldEn(ldEn), .ldIdx(ldIdx), .ldData(ldData), .wb(wb), .issue(issue));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic summarize;
      $display("checks %0d errors %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // a wait that runs out is a mismatch and ends the run
   task automatic hang(input string what);
      errCount++;
      $display("ERROR %s expected a response seen none", what);
      summarize();
   endtask : hang

   // write: address and data offered together, each dropped once taken
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
            break;
      end
      if (n == 50)
         hang("bvalid");
      r = bresp;
      bready <= 1'b0;
      @(posedge mclk);
   endtask : axiWrite

   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
            break;
      end
      if (n == 50)
         hang("rvalid");
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge mclk);
   endtask : axiRead

   task automatic load2(input logic [4:0] i1, input logic [31:0] v1,
                        input logic [4:0] i2, input logic [31:0] v2);
      ldEn   <= 1'b1;
      ldIdx  <= i1;
      ldData <= v1;
      @(posedge mclk);
      ldIdx  <= i2;
      ldData <= v2;
      @(posedge mclk);
      ldEn   <= 0;
   endtask : load2

   // request held one cycle; last=0 keeps valid up for a back-to-back follower
   task automatic send(input logic [31:0] ins, input logic last);
      reqValid <= 1'b1;
      reqInstr <= ins;
      @(posedge mclk);
      if (last)
         reqValid <= 1'b0;
   endtask : send

   // expected result and flags are computed here from 33-bit arithmetic
   task automatic expectWb(input logic [5:0] op, input logic [31:0] a, b, input logic [4:0] d);
      logic [32:0] r;
      logic [31:0] res;
      logic        ovf;
      int          n;
      r   = (op == OP_ADD_REG) ? {1'b0, a} + {1'b0, b} : {1'b0, a} - {1'b0, b};
      ovf = (op == OP_ADD_REG) ? (a[31] == b[31]) : (a[31] != b[31]);
      ovf = ovf && (r[31] != a[31]);
      res = ovf ? (a[31] ? CLAMP_NEG : CLAMP_POS) : r[31:0];
      clampExp = clampExp | ovf;
      ovfCount += int'(ovf);
      statusExp = {clampExp, r[32], ovf, res[31], res == 32'h0};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wb.valid !== 1'b1 && n < 8);
      if (wb.valid !== 1'b1)
         hang("wb.valid");
      chk("wb.index", {27'h0, d}, {27'h0, wb.index});
      chk("wb.data", res, wb.data);
      chk("status", {27'h0, statusExp}, {27'h0, status});
   endtask : expectWb

   task automatic expectNone;
      logic seen;
      seen = 1'b0;
      repeat (4) begin
         @(posedge mclk);
         seen = seen | wb.valid;
      end
      chk("wb.valid idle", 32'h0, {31'h0, seen});
      chk("status kept", {27'h0, statusExp}, {27'h0, status});
   endtask : expectNone

   initial begin
      logic [31:0] rd;
      logic [1:0]  rs;
      {rst_n, reqValid, ldEn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {reqInstr, ldData, wdata, ldIdx, awaddr, araddr, wstrb} = '0;
      {errCount, checkCount, ovfCount, clampExp, statusExp} = '0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk("status reset", 32'h0, {27'h0, status});
      axiRead(OFF_CTRL, rd, rs);
      chk("ctrl reset", {31'h0, CTRL_EN_RST}, rd);
      // destination minus source; overflow cases fourth and fifth, then sticky flag survives plain ops
      for (int i = 0; i < 7; i++) begin
         load2(5'd2, va[i], 5'd3, vb[i]);
         send({16'h0, 5'd2, OP_SUB_REG, 5'd3}, 1'b1);
         expectWb(OP_SUB_REG, va[i], vb[i], 5'd2);
      end
      for (int i = 0; i < 4; i++) begin
         load2(5'd4, is[i], 5'd5, 32'h5a5a5a5a);
         send({im[i], 5'd5, OP_SUB_IMM, 5'd4}, 1'b1);
         expectWb(OP_SUB_IMM, is[i], {{16{im[i][15]}}, im[i]}, 5'd5);
      end
      load2(5'd6, 32'h7fffffff, 5'd7, 32'd1);
      send({16'h0, 5'd6, OP_ADD_REG, 5'd7}, 1'b1);
      expectWb(OP_ADD_REG, 32'h7fffffff, 32'd1, 5'd6);
      // back to back on independent registers
      load2(5'd8, 32'hffffffff, 5'd9, 32'd1);
      send({16'h0, 5'd8, OP_ADD_REG, 5'd9}, 1'b0);
      send({16'h0001, 5'd10, OP_SUB_IMM, 5'd9}, 1'b1);
      expectWb(OP_ADD_REG, 32'hffffffff, 32'd1, 5'd8);
      expectWb(OP_SUB_IMM, 32'd1, 32'd1, 5'd10);
      axiRead(OFF_SATCNT, rd, rs);
      chk("satcnt", ovfCount, rd);
      axiRead(OFF_RESULT, rd, rs);
      chk("result zero", 32'h0, rd);
      // unknown opcode and disabled unit both leave ports quiet
      send({16'h0, 5'd2, 6'h07, 5'd3}, 1'b1);
      expectNone();
      axiWrite(OFF_CTRL, 32'h0, rs);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
      send({16'h0, 5'd2, OP_SUB_REG, 5'd3}, 1'b1);
      expectNone();
      // enable again and clear the overflow count; the clear bit reads back zero
      axiWrite(OFF_CTRL, 32'h3, rs);
      axiRead(OFF_SATCNT, rd, rs);
      chk("satcnt cleared", 32'h0, rd);
      axiRead(OFF_CTRL, rd, rs);
      chk("ctrl enabled", 32'h1, rd);
      // status load is the only way to drop the sticky flag
      axiWrite(OFF_STATUS, 32'h0, rs);
      {clampExp, statusExp} = '0;
      axiRead(OFF_STATUS, rd, rs);
      chk("status cleared", 32'h0, rd);
      load2(5'd2, 32'd9, 5'd3, 32'd2);
      send({16'h0, 5'd2, OP_SUB_REG, 5'd3}, 1'b1);
      expectWb(OP_SUB_REG, 32'd9, 32'd2, 5'd2);
      axiRead(OFF_RESULT, rd, rs);
      chk("result", 32'd7, rd);
      axiWrite(8'h40, 32'h1, rs);
      chk("bresp unmapped", {30'h0, RESP_DECERR}, {30'h0, rs});
      axiRead(8'h40, rd, rs);
      chk("rresp unmapped", {30'h0, RESP_DECERR}, {30'h0, rs});
      chk("rdata unmapped", 32'h0, rd);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
